// File: rtl/lfss_pkg.sv
// lfss_pkg: constants and types of the lock, fuse and signature store
// assumes: one clock domain, shared by the store, its decoder and its memory
package lfss_pkg;

  // byte index of each non-volatile byte, equal to the software read pointer
  localparam logic [1:0] IDX_LOW = 2'h0;
  localparam logic [1:0] IDX_LOCK = 2'h1;
  localparam logic [1:0] IDX_EXT = 2'h2;
  localparam logic [1:0] IDX_HIGH = 2'h3;
  localparam int unsigned NV_WORDS = 4;

  // reset (shipped) values, programmed bit = 0
  localparam logic [7:0] LOCK_RST = 8'hFF;
  localparam logic [7:0] EXT_RST = 8'hFF;
  localparam logic [7:0] HIGH_RST = 8'hDF;
  localparam logic [7:0] LOW_RST = 8'h62;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] LOCK_UNUSED_MASK = 8'hFC;
  localparam logic [7:0] EXT_UNUSED_MASK = 8'hFE;

  // field positions
  localparam int unsigned LOCK_LOW_BIT = 0;
  localparam int unsigned LOCK_HIGH_BIT = 1;
  localparam int unsigned SELF_PROG_BIT = 0;
  localparam int unsigned EXT_RST_DIS_BIT = 7;
  localparam int unsigned DEBUG_EN_BIT = 6;
  localparam int unsigned SERIAL_PROG_BIT = 5;
  localparam int unsigned WDT_ON_BIT = 4;
  localparam int unsigned PRESERVE_BIT = 3;
  localparam int unsigned BOD_LSB = 0;
  localparam int unsigned CLK_DIV8_BIT = 7;
  localparam int unsigned CLK_OUT_BIT = 6;
  localparam int unsigned SUT_LSB = 4;
  localparam int unsigned CKSEL_LSB = 0;

  // signature space addresses
  localparam logic [1:0] SIG_ADDR0 = 2'h0;
  localparam logic [1:0] SIG_ADDR1 = 2'h1;
  localparam logic [1:0] SIG_ADDR2 = 2'h2;

  // software control byte
  localparam logic [4:0] SPM_CMD_MASK = 5'h1F;
  localparam logic [4:0] SPM_RD_CFG_CMD = 5'h09;
  localparam logic [7:0] SPM_RD_CFG_FLAGS = 8'h09;
  localparam logic [1:0] RD_WINDOW_CYC = 2'h3;

  typedef struct packed {
    logic [7:0] ext;
    logic [7:0] high;
    logic [7:0] low;
  } lfss_cfg_t;

  typedef enum logic [2:0] {
    OP_RD_CFG = 3'h0,
    OP_WR_CFG = 3'h1,
    OP_RD_SIG = 3'h2,
    OP_RD_CAL = 3'h3,
    OP_ERASE = 3'h4,
    OP_MEM_WR = 3'h5,
    OP_MEM_RD = 3'h6
  } lfss_op_t;

  typedef struct packed {
    logic valid;
    lfss_op_t op;
    logic [1:0] idx;
    logic [7:0] data;
  } lfss_cmd_t;

  typedef struct packed {
    logic [1:0] mode;
    logic mem_prog_ok;
    logic mem_verify_ok;
    logic fuse_frozen;
    logic debug_ok;
  } lfss_perm_t;

  localparam logic [1:0] MODE_1 = 2'h1;
  localparam logic [1:0] MODE_2 = 2'h2;
  localparam logic [1:0] MODE_3 = 2'h3;

  typedef enum logic [2:0] {
    ST_BOOT = 3'b001,
    ST_RUN = 3'b010,
    ST_RESP = 3'b100
  } lfss_state_t;

endpackage

// File: rtl/lfss_nv_store.sv
// lfss_nv_store: the non-volatile bytes, one write port, two registered reads
// assumes: reset stands for a blank part; writer does its own masking
`timescale 1ns/10ps
module lfss_nv_store #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4,
  parameter logic [WIDTH*DEPTH-1:0] INIT = '1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_idx,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [$clog2(DEPTH)-1:0] rd_a_idx,
  input wire logic [$clog2(DEPTH)-1:0] rd_b_idx,
  output logic [WIDTH-1:0] rd_a_data_r,
  output logic [WIDTH-1:0] rd_b_data_r,
  output logic [WIDTH*DEPTH-1:0] contents
);
  logic [WIDTH-1:0] rd_a_nxt;
  logic [WIDTH-1:0] rd_b_nxt;

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_word
      logic [WIDTH-1:0] word_r;
      logic [WIDTH-1:0] word_nxt;
      always_comb begin
        word_nxt = word_r;
        if (wr_en && (wr_idx == ($clog2(DEPTH))'(g))) begin
          word_nxt = wr_data;
        end
      end
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          word_r <= INIT[g*WIDTH +: WIDTH];
        end else begin
          word_r <= word_nxt;
        end
      end
      assign contents[g*WIDTH +: WIDTH] = word_r;
    end
  endgenerate

  always_comb begin
    rd_a_nxt = contents[rd_a_idx*WIDTH +: WIDTH];
    rd_b_nxt = contents[rd_b_idx*WIDTH +: WIDTH];
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_a_data_r <= '1;
      rd_b_data_r <= '1;
    end else begin
      rd_a_data_r <= rd_a_nxt;
      rd_b_data_r <= rd_b_nxt;
    end
  end
endmodule // lfss_nv_store

// File: rtl/lfss_lock_decode.sv
// lfss_lock_decode: lock bits to protection mode and permissions
// assumes: inputs are the latched working copies, not the live store
`timescale 1ns/10ps
module lfss_lock_decode
  import lfss_pkg::*;
(
  input wire logic [1:0] lock_bits,
  input wire logic debug_fuse,
  output lfss_pkg::lfss_perm_t perm
);
  always_comb begin
    perm = '0;
    case (lock_bits)
      2'b11: perm.mode = MODE_1;
      2'b10: perm.mode = MODE_2;
      default: perm.mode = MODE_3;
    endcase
    perm.mem_prog_ok = (perm.mode == MODE_1);
    perm.mem_verify_ok = (perm.mode != MODE_3);
    perm.fuse_frozen = (perm.mode != MODE_1);
    perm.debug_ok = (perm.mode == MODE_1) && !debug_fuse;
  end
endmodule // lfss_lock_decode

// File: rtl/lfss_store.sv
// lfss_store: lock, fuse, signature and trim store with programmer and cpu ports
// assumes: programmer commands only while prog_mode; cpu halted in programming
`timescale 1ns/10ps

module lfss_store
  import lfss_pkg::*;
#(
  parameter logic [7:0] SIG_BYTE0 = 8'h5A, // arbitrary identity value
  parameter logic [7:0] SIG_BYTE1 = 8'h3C, // arbitrary identity value
  parameter logic [7:0] SIG_BYTE2 = 8'hA5, // arbitrary identity value
  parameter logic [7:0] CAL_BYTE = 8'h80
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cpu_rst,
  input wire logic prog_mode,
  input wire logic prog_serial,
  input wire lfss_pkg::lfss_cmd_t prog_cmd,
  output logic prog_cmd_ready,
  output logic prog_rsp_valid_r,
  output logic [7:0] prog_rsp_data_r,
  output logic prog_rsp_refused_r,
  input wire logic spm_ctrl_wr,
  input wire logic [7:0] spm_ctrl_data,
  output logic [7:0] spm_ctrl_flags,
  input wire logic sw_load,
  input wire logic [15:0] sw_pointer,
  output logic sw_rvalid_r,
  output logic [7:0] sw_rdata_r,
  output lfss_pkg::lfss_cfg_t work_cfg_r,
  output lfss_pkg::lfss_perm_t perm,
  output logic data_memory_preserve,
  output logic prog_mem_erase_r,
  output logic data_mem_erase_r,
  output logic [7:0] oscillator_trim_register_r
);
  import lfss_pkg::*;

  lfss_state_t state_r, state_nxt;
  lfss_cfg_t work_cfg_nxt;
  logic [1:0] work_lock_r, work_lock_nxt;
  logic prog_mode_d_r;
  lfss_op_t pend_op_r, pend_op_nxt;
  logic [1:0] pend_idx_r, pend_idx_nxt;
  logic pend_refused_r, pend_refused_nxt;
  logic prog_rsp_valid_nxt;
  logic [7:0] prog_rsp_data_nxt;
  logic prog_rsp_refused_nxt;
  logic prog_mem_erase_nxt;
  logic data_mem_erase_nxt;
  logic [7:0] trim_nxt;
  logic [1:0] sw_win_r, sw_win_nxt;
  logic sw_pend_r, sw_pend_nxt;
  logic sw_rvalid_nxt;
  logic [7:0] sw_rdata_nxt;

  logic mem_we;
  logic [1:0] mem_widx;
  logic [7:0] mem_wdata;
  logic [1:0] sw_idx;
  logic [7:0] rd_a_data;
  logic [7:0] rd_b_data;
  logic [8*NV_WORDS-1:0] nv_flat;
  logic [7:0] nv_lock;
  logic [7:0] nv_high;
  logic cmd_take;
  logic fuse_locked;
  logic latch_now;

  lfss_nv_store #(
    .WIDTH(8),
    .DEPTH(NV_WORDS),
    .INIT({HIGH_RST, EXT_RST, LOCK_RST, LOW_RST})
  ) u_nv (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_en(mem_we),
    .wr_idx(mem_widx),
    .wr_data(mem_wdata),
    .rd_a_idx(prog_cmd.idx),
    .rd_b_idx(sw_idx),
    .rd_a_data_r(rd_a_data),
    .rd_b_data_r(rd_b_data),
    .contents(nv_flat)
  );

  lfss_lock_decode u_dec (
    .lock_bits(work_lock_r),
    .debug_fuse(work_cfg_r.high[DEBUG_EN_BIT]),
    .perm(perm)
  );

  assign nv_lock = nv_flat[IDX_LOCK*8 +: 8];
  assign nv_high = nv_flat[IDX_HIGH*8 +: 8];
  assign data_memory_preserve = !nv_high[PRESERVE_BIT];
  assign prog_cmd_ready = (state_r == ST_RUN) && prog_mode;
  assign cmd_take = prog_cmd_ready && prog_cmd.valid;
  // live lower lock bit also freezes fuses
  assign fuse_locked = perm.fuse_frozen || !nv_lock[LOCK_LOW_BIT];
  // capture on entry, apply on exit
  assign latch_now = (state_r == ST_BOOT) || (prog_mode != prog_mode_d_r);
  assign sw_idx = sw_pointer[1:0];
  assign spm_ctrl_flags = (sw_win_r != 2'h0) ? SPM_RD_CFG_FLAGS : 8'h00;

  // programmer side and latches
  always_comb begin
    state_nxt = state_r;
    work_cfg_nxt = work_cfg_r;
    work_lock_nxt = work_lock_r;
    pend_op_nxt = pend_op_r;
    pend_idx_nxt = pend_idx_r;
    pend_refused_nxt = pend_refused_r;
    prog_rsp_valid_nxt = 1'b0;
    prog_rsp_data_nxt = prog_rsp_data_r;
    prog_rsp_refused_nxt = 1'b0;
    prog_mem_erase_nxt = 1'b0;
    data_mem_erase_nxt = 1'b0;
    mem_we = 1'b0;
    mem_widx = prog_cmd.idx;
    mem_wdata = prog_cmd.data;
    if (latch_now) begin
      work_cfg_nxt.ext = nv_flat[IDX_EXT*8 +: 8];
      work_cfg_nxt.high = nv_high;
      work_cfg_nxt.low = nv_flat[IDX_LOW*8 +: 8];
      work_lock_nxt = nv_lock[1:0];
    end
    case (state_r)
      ST_BOOT: state_nxt = ST_RUN;
      ST_RUN: begin
        if (cmd_take) begin
          state_nxt = ST_RESP;
          pend_op_nxt = prog_cmd.op;
          pend_idx_nxt = prog_cmd.idx;
          pend_refused_nxt = 1'b0;
          case (prog_cmd.op)
            OP_WR_CFG: begin
              if (prog_cmd.idx == IDX_LOCK) begin
                // writes may only program lock bits
                mem_we = 1'b1;
                mem_wdata = nv_lock & (prog_cmd.data | LOCK_UNUSED_MASK);
              end else if (fuse_locked) begin
                pend_refused_nxt = 1'b1;
              end else begin
                mem_we = 1'b1;
                if (prog_cmd.idx == IDX_EXT) begin
                  mem_wdata = prog_cmd.data | EXT_UNUSED_MASK;
                end
                if ((prog_cmd.idx == IDX_HIGH) && prog_serial) begin
                  mem_wdata[SERIAL_PROG_BIT] = nv_high[SERIAL_PROG_BIT];
                end
              end
            end
            OP_RD_SIG: pend_refused_nxt = (prog_cmd.idx > SIG_ADDR2);
            OP_ERASE: begin
              mem_we = 1'b1;
              mem_widx = IDX_LOCK;
              mem_wdata = ERASED_BYTE;
              prog_mem_erase_nxt = 1'b1;
              data_mem_erase_nxt = nv_high[PRESERVE_BIT];
            end
            OP_MEM_WR: pend_refused_nxt = !perm.mem_prog_ok;
            OP_MEM_RD: pend_refused_nxt = !perm.mem_verify_ok;
            default: pend_refused_nxt = 1'b0;
          endcase
        end
      end
      ST_RESP: begin
        state_nxt = ST_RUN;
        prog_rsp_valid_nxt = 1'b1;
        prog_rsp_refused_nxt = pend_refused_r;
        prog_rsp_data_nxt = ERASED_BYTE;
        case (pend_op_r)
          OP_RD_CFG: begin
            prog_rsp_data_nxt = rd_a_data;
            // serial fuse hidden in serial mode
            if ((pend_idx_r == IDX_HIGH) && prog_serial) begin
              prog_rsp_data_nxt[SERIAL_PROG_BIT] = 1'b1;
            end
          end
          OP_RD_SIG: begin
            case (pend_idx_r)
              SIG_ADDR0: prog_rsp_data_nxt = SIG_BYTE0;
              SIG_ADDR1: prog_rsp_data_nxt = SIG_BYTE1;
              SIG_ADDR2: prog_rsp_data_nxt = SIG_BYTE2;
              default: prog_rsp_data_nxt = ERASED_BYTE;
            endcase
          end
          OP_RD_CAL: prog_rsp_data_nxt = CAL_BYTE;
          default: prog_rsp_data_nxt = ERASED_BYTE;
        endcase
      end
      default: state_nxt = ST_BOOT;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ST_BOOT;
      work_cfg_r <= {EXT_RST, HIGH_RST, LOW_RST};
      work_lock_r <= LOCK_RST[1:0];
      prog_mode_d_r <= 1'b0;
      pend_op_r <= OP_RD_CFG;
      pend_idx_r <= 2'h0;
      pend_refused_r <= 1'b0;
      prog_rsp_valid_r <= 1'b0;
      prog_rsp_data_r <= 8'h00;
      prog_rsp_refused_r <= 1'b0;
      prog_mem_erase_r <= 1'b0;
      data_mem_erase_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      work_cfg_r <= work_cfg_nxt;
      work_lock_r <= work_lock_nxt;
      prog_mode_d_r <= prog_mode;
      pend_op_r <= pend_op_nxt;
      pend_idx_r <= pend_idx_nxt;
      pend_refused_r <= pend_refused_nxt;
      prog_rsp_valid_r <= prog_rsp_valid_nxt;
      prog_rsp_data_r <= prog_rsp_data_nxt;
      prog_rsp_refused_r <= prog_rsp_refused_nxt;
      prog_mem_erase_r <= prog_mem_erase_nxt;
      data_mem_erase_r <= data_mem_erase_nxt;
    end
  end

  // software read path and trim
  always_comb begin
    sw_win_nxt = sw_win_r;
    sw_pend_nxt = 1'b0;
    sw_rvalid_nxt = sw_pend_r;
    sw_rdata_nxt = sw_rdata_r;
    trim_nxt = oscillator_trim_register_r;
    if (cpu_rst || (state_r == ST_BOOT)) begin
      trim_nxt = CAL_BYTE;
    end
    if (sw_pend_r) begin
      sw_rdata_nxt = rd_b_data;
    end
    if (sw_win_r != 2'h0) begin
      sw_win_nxt = sw_win_r - 2'h1;
    end
    if ((sw_win_r != 2'h0) && sw_load && (sw_pointer[15:2] == 14'h0)) begin
      sw_pend_nxt = 1'b1;
      sw_win_nxt = 2'h0;
    end
    if (spm_ctrl_wr && ((spm_ctrl_data[4:0] & SPM_CMD_MASK) == SPM_RD_CFG_CMD)) begin
      sw_win_nxt = RD_WINDOW_CYC;
    end
    // cpu reset closes the read window and drops a load taken in the same cycle
    if (cpu_rst) begin
      sw_win_nxt = 2'h0;
      sw_pend_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sw_win_r <= 2'h0;
      sw_pend_r <= 1'b0;
      sw_rvalid_r <= 1'b0;
      sw_rdata_r <= 8'h00;
      oscillator_trim_register_r <= CAL_BYTE;
    end else begin
      sw_win_r <= sw_win_nxt;
      sw_pend_r <= sw_pend_nxt;
      sw_rvalid_r <= sw_rvalid_nxt;
      sw_rdata_r <= sw_rdata_nxt;
      oscillator_trim_register_r <= trim_nxt;
    end
  end
endmodule // lfss_store

// File: verification/lfss_store_checker.sv
// lfss_store_checker: port-level checks of the lock, fuse and signature store
// assumes: bound to lfss_store, one clock domain, reset sys_rst
`timescale 1ns/10ps
module lfss_store_checker
  import lfss_pkg::*;
#(
  parameter logic [7:0] CAL_BYTE = 8'h80
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cpu_rst,
  input wire logic prog_mode,
  input wire lfss_pkg::lfss_cmd_t prog_cmd,
  input wire logic prog_cmd_ready,
  input wire logic prog_rsp_valid_r,
  input wire logic prog_rsp_refused_r,
  input wire logic spm_ctrl_wr,
  input wire logic [7:0] spm_ctrl_data,
  input wire logic [7:0] spm_ctrl_flags,
  input wire logic sw_load,
  input wire logic [15:0] sw_pointer,
  input wire logic sw_rvalid_r,
  input wire lfss_pkg::lfss_cfg_t work_cfg_r,
  input wire lfss_pkg::lfss_perm_t perm,
  input wire logic data_memory_preserve,
  input wire logic prog_mem_erase_r,
  input wire logic data_mem_erase_r,
  input wire logic [7:0] oscillator_trim_register_r
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  logic take;
  assign take = prog_cmd.valid && prog_cmd_ready;
  property p_sig;
    take && prog_cmd.op == OP_RD_SIG && prog_cmd.idx != 2'h3
      |=> !prog_cmd_ready ##1 (prog_rsp_valid_r && !prog_rsp_refused_r);
  endproperty
  a_sig: assert property (p_sig)
    else $error("signature read not answered");
  property p_frozen;
    take && prog_cmd.op == OP_WR_CFG && prog_cmd.idx != IDX_LOCK && perm.fuse_frozen
      |-> ##2 prog_rsp_refused_r;
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("fuse write accepted while frozen");
  property p_mem_wr;
    take && prog_cmd.op == OP_MEM_WR |-> ##2 prog_rsp_refused_r == (perm.mode != MODE_1);
  endproperty
  a_mem_wr: assert property (p_mem_wr)
    else $error("memory programming permission wrong");
  property p_mem_rd;
    take && prog_cmd.op == OP_MEM_RD |-> ##2 prog_rsp_refused_r == (perm.mode == MODE_3);
  endproperty
  a_mem_rd: assert property (p_mem_rd)
    else $error("memory verify permission wrong");
  property p_mode1;
    perm.mode == MODE_1 |-> perm.mem_prog_ok && perm.mem_verify_ok && !perm.fuse_frozen;
  endproperty
  a_mode1: assert property (p_mode1)
    else $error("open mode applies locking");
  property p_locked;
    perm.mode != MODE_1 |-> !perm.mem_prog_ok && perm.fuse_frozen && !perm.debug_ok
      && perm.mem_verify_ok == (perm.mode == MODE_2);
  endproperty
  a_locked: assert property (p_locked)
    else $error("locked mode permissions wrong");
  property p_erase;
    prog_mem_erase_r |-> $past(take) && $past(prog_cmd.op) == OP_ERASE
      && data_mem_erase_r == !data_memory_preserve;
  endproperty
  a_erase: assert property (p_erase)
    else $error("erase pulse or data preserve wrong");
  property p_trim;
    cpu_rst |=> oscillator_trim_register_r == CAL_BYTE;
  endproperty
  a_trim: assert property (p_trim)
    else $error("trim not reloaded on reset");
  property p_latch;
    $past(prog_mode) && $past(prog_mode, 2) |-> $stable(work_cfg_r);
  endproperty
  a_latch: assert property (p_latch)
    else $error("working fuses changed in session");
  property p_arm;
    spm_ctrl_wr && spm_ctrl_data[4:0] == SPM_RD_CFG_CMD && !cpu_rst
      |=> spm_ctrl_flags == SPM_RD_CFG_FLAGS;
  endproperty
  a_arm: assert property (p_arm)
    else $error("read window not armed");
  property p_sw_rd;
    sw_rvalid_r |-> $past(sw_load, 2) && $past(sw_pointer, 2) < 16'h0004;
  endproperty
  a_sw_rd: assert property (p_sw_rd)
    else $error("software read without load");
  property p_sw_off;
    sw_load && spm_ctrl_flags == 8'h00 |-> ##2 !sw_rvalid_r;
  endproperty
  a_sw_off: assert property (p_sw_off)
    else $error("load outside window answered");
  c_keep: cover property (prog_mem_erase_r && !data_mem_erase_r);
  c_swrd: cover property (sw_rvalid_r);
  c_mode3: cover property (perm.mode == MODE_3);
endmodule // lfss_store_checker

bind lfss_store lfss_store_checker #(.CAL_BYTE(CAL_BYTE)) u_lfss_chk (
  .clk, .sys_rst, .cpu_rst, .prog_mode, .prog_cmd, .prog_cmd_ready, .prog_rsp_valid_r,
  .prog_rsp_refused_r, .spm_ctrl_wr, .spm_ctrl_data, .spm_ctrl_flags, .sw_load,
  .sw_pointer, .sw_rvalid_r, .work_cfg_r, .perm, .data_memory_preserve,
  .prog_mem_erase_r, .data_mem_erase_r, .oscillator_trim_register_r
);

// File: verification/lfss_programmer.sv
// lfss_programmer: behavioural memory programmer on the store's command port
// assumes: one command in flight, ready and response seen at the falling edge
`timescale 1ns/10ps
module lfss_programmer
  import lfss_pkg::*;
(
  input wire logic clk,
  input wire logic prog_cmd_ready,
  input wire logic prog_rsp_valid_r,
  input wire logic [7:0] prog_rsp_data_r,
  input wire logic prog_rsp_refused_r,
  output logic prog_mode,
  output logic prog_serial,
  output lfss_pkg::lfss_cmd_t prog_cmd
);
  initial begin
    prog_mode = 1'b0;
    prog_serial = 1'b0;
    prog_cmd = '0;
  end
  task automatic enter(input logic serial);
    @(posedge clk);
    prog_mode <= 1'b1;
    prog_serial <= serial;
    repeat (3) @(posedge clk);
  endtask
  task automatic leave();
    @(posedge clk);
    prog_mode <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic cmd(input lfss_op_t op, input logic [1:0] idx, input logic [7:0] d,
      output logic [7:0] rd, output logic rf, output bit ok);
    int n;
    ok = 1'b0;
    @(posedge clk);
    prog_cmd <= '{valid: 1'b1, op: op, idx: idx, data: d};
    for (n = 0; n < 16; n++) begin
      @(negedge clk);
      if (prog_cmd_ready) break;
    end
    @(posedge clk);
    prog_cmd.valid <= 1'b0;
    for (n = 0; n < 8 && !ok; n++) begin
      @(negedge clk);
      ok = prog_rsp_valid_r;
    end
    rd = prog_rsp_data_r;
    rf = prog_rsp_refused_r;
  endtask
endmodule // lfss_programmer

// File: verification/lfss_store_tb.sv
// lfss_store_tb: directed sequences through programmer and software read ports
// assumes: programmer model drives the command port, bench drives the cpu side
`timescale 1ns/10ps
module lfss_store_tb;
  import lfss_pkg::*;
  // arbitrary identity values
  localparam logic [7:0] SIG [4] = '{8'h11, 8'h22, 8'h33, 8'hFF};
  localparam logic [7:0] CAL = 8'h6B;
  localparam logic [7:0] DFLT [4] = '{8'h62, 8'hFF, 8'hFF, 8'hDF};
  logic clk, sys_rst, cpu_rst, prog_mode, prog_serial, prog_cmd_ready, prog_rsp_valid_r;
  logic prog_rsp_refused_r, spm_ctrl_wr, sw_load, sw_rvalid_r, data_memory_preserve;
  logic prog_mem_erase_r, data_mem_erase_r;
  logic [7:0] prog_rsp_data_r, spm_ctrl_data, spm_ctrl_flags, sw_rdata_r;
  logic [7:0] oscillator_trim_register_r;
  logic [15:0] sw_pointer;
  lfss_cmd_t prog_cmd;
  lfss_cfg_t work_cfg_r;
  lfss_perm_t perm;
  int fail_count = 0;
  int samples_checked = 0;
  int i;
  lfss_store #(.SIG_BYTE0(SIG[0]), .SIG_BYTE1(SIG[1]), .SIG_BYTE2(SIG[2]),
    .CAL_BYTE(CAL)) DUT (.clk, .sys_rst, .cpu_rst, .prog_mode, .prog_serial, .prog_cmd,
    .prog_cmd_ready, .prog_rsp_valid_r, .prog_rsp_data_r, .prog_rsp_refused_r,
    .spm_ctrl_wr, .spm_ctrl_data, .spm_ctrl_flags, .sw_load, .sw_pointer, .sw_rvalid_r,
    .sw_rdata_r, .work_cfg_r, .perm, .data_memory_preserve, .prog_mem_erase_r,
    .data_mem_erase_r, .oscillator_trim_register_r);
  lfss_programmer p (.clk, .prog_cmd_ready, .prog_rsp_valid_r, .prog_rsp_data_r,
    .prog_rsp_refused_r, .prog_mode, .prog_serial, .prog_cmd);
  always #25 clk = ~clk;
  task automatic results();
    $display("compared %0d mismatched %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic pc(input lfss_op_t op, input logic [1:0] idx, input logic [7:0] d,
      input logic [7:0] exp, input logic rf_exp);
    logic [7:0] rd;
    logic rf;
    bit ok;
    p.cmd(op, idx, d, rd, rf, ok);
    if (!ok) begin
      fail_count++;
      results();
    end
    chk("refused", {7'h0, rf}, {7'h0, rf_exp});
    if (op inside {OP_RD_CFG, OP_RD_SIG, OP_RD_CAL}) chk("rsp_data", rd, exp);
  endtask
  task automatic sw_rd(input logic [15:0] ptr, input int dly, input logic [7:0] exp,
      input logic hit);
    @(posedge clk);
    spm_ctrl_wr <= 1'b1;
    spm_ctrl_data <= SPM_RD_CFG_FLAGS;
    @(posedge clk);
    spm_ctrl_wr <= 1'b0;
    for (int k = 1; k < dly; k++) @(posedge clk);
    sw_load <= 1'b1;
    sw_pointer <= ptr;
    @(posedge clk);
    sw_load <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk("sw_rvalid", {7'h0, sw_rvalid_r}, {7'h0, hit});
    if (hit) chk("sw_rdata", sw_rdata_r, exp);
  endtask
  task automatic relatch(input logic s);
    p.leave();
    p.enter(s);
    @(negedge clk);
  endtask
  task automatic mode_is(input logic [1:0] m);
    chk("mode", {6'h0, perm.mode}, {6'h0, m});
  endtask
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    cpu_rst = 1'b0;
    spm_ctrl_wr = 1'b0;
    spm_ctrl_data = 8'h00;
    sw_load = 1'b0;
    sw_pointer = 16'h0000;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("trim", oscillator_trim_register_r, CAL);
    chk("work_high", work_cfg_r.high, 8'hDF);
    chk("work_low", work_cfg_r.low, 8'h62);
    for (i = 0; i < 4; i++) sw_rd(i[15:0], 1, DFLT[i], 1'b1);
    sw_rd(16'h0001, 3, 8'hFF, 1'b1);
    sw_rd(16'h0001, 4, 8'hFF, 1'b0);
    sw_rd(16'h0004, 1, 8'hFF, 1'b0);
    p.enter(1'b0);
    for (i = 0; i < 4; i++) pc(OP_RD_CFG, i[1:0], 8'h00, DFLT[i], 1'b0);
    for (i = 0; i < 4; i++) pc(OP_RD_SIG, i[1:0], 8'h00, SIG[i], i == 3);
    pc(OP_RD_CAL, 2'h0, 8'h00, CAL, 1'b0);
    pc(OP_ERASE, 2'h0, 8'h00, 8'h00, 1'b0);
    pc(OP_MEM_WR, 2'h0, 8'h00, 8'h00, 1'b0);
    pc(OP_MEM_RD, 2'h0, 8'h00, 8'h00, 1'b0);
    pc(OP_WR_CFG, IDX_EXT, 8'h00, 8'h00, 1'b0);
    pc(OP_RD_CFG, IDX_EXT, 8'h00, 8'hFE, 1'b0);
    pc(OP_WR_CFG, IDX_HIGH, 8'hD7, 8'h00, 1'b0);
    chk("preserve", {7'h0, data_memory_preserve}, 8'h01);
    chk("work_high", work_cfg_r.high, 8'hDF);
    pc(OP_ERASE, 2'h0, 8'h00, 8'h00, 1'b0);
    pc(OP_RD_CFG, IDX_HIGH, 8'h00, 8'hD7, 1'b0);
    pc(OP_WR_CFG, IDX_LOCK, 8'hFE, 8'h00, 1'b0);
    pc(OP_WR_CFG, IDX_HIGH, 8'hDF, 8'h00, 1'b1);
    mode_is(MODE_1);
    relatch(1'b0);
    chk("work_high", work_cfg_r.high, 8'hD7);
    chk("work_ext", work_cfg_r.ext, 8'hFE);
    mode_is(MODE_2);
    pc(OP_MEM_WR, 2'h0, 8'h00, 8'h00, 1'b1);
    pc(OP_MEM_RD, 2'h0, 8'h00, 8'h00, 1'b0);
    pc(OP_WR_CFG, IDX_LOW, 8'h62, 8'h00, 1'b1);
    pc(OP_RD_SIG, 2'h0, 8'h00, SIG[0], 1'b0);
    pc(OP_WR_CFG, IDX_LOCK, 8'hFC, 8'h00, 1'b0);
    pc(OP_WR_CFG, IDX_LOCK, 8'hFF, 8'h00, 1'b0);
    pc(OP_RD_CFG, IDX_LOCK, 8'h00, 8'hFC, 1'b0);
    relatch(1'b0);
    mode_is(MODE_3);
    pc(OP_MEM_RD, 2'h0, 8'h00, 8'h00, 1'b1);
    pc(OP_ERASE, 2'h0, 8'h00, 8'h00, 1'b0);
    pc(OP_RD_CFG, IDX_LOCK, 8'h00, 8'hFF, 1'b0);
    pc(OP_WR_CFG, IDX_LOCK, 8'hFD, 8'h00, 1'b0);
    relatch(1'b0);
    mode_is(MODE_3);
    pc(OP_ERASE, 2'h0, 8'h00, 8'h00, 1'b0);
    relatch(1'b1);
    mode_is(MODE_1);
    pc(OP_RD_CFG, IDX_HIGH, 8'h00, 8'hF7, 1'b0);
    pc(OP_WR_CFG, IDX_HIGH, 8'hF7, 8'h00, 1'b0);
    relatch(1'b0);
    pc(OP_RD_CFG, IDX_HIGH, 8'h00, 8'hD7, 1'b0);
    pc(OP_WR_CFG, IDX_EXT, 8'hFF, 8'h00, 1'b0);
    chk("work_ext", work_cfg_r.ext, 8'hFE);
    p.leave();
    cpu_rst <= 1'b1;
    @(posedge clk);
    cpu_rst <= 1'b0;
    @(negedge clk);
    chk("trim", oscillator_trim_register_r, CAL);
    chk("work_ext", work_cfg_r.ext, 8'hFF);
    sw_rd(16'h0003, 2, 8'hD7, 1'b1);
    results();
  end
endmodule // lfss_store_tb
